// [verilog/smdc_pkg.sv]
// Purpose: Shared constants and types for the six-mode down counter.
// Assumes: One 8-bit control word per write, one count channel per block.
// Notes:   Field layout of the control word is carried by smdc_ctrl_s.

// ********************************************************************
// Package
// ********************************************************************
package smdc_pkg;

  // Control word layout, msb first
  typedef struct packed {
    logic channel_select_hi;
    logic channel_select_lo;
    logic load_format_hi;
    logic load_format_lo;
    logic waveform_sel_2;
    logic waveform_sel_1;
    logic waveform_sel_0;
    logic bcd_count;
  } smdc_ctrl_s;

  // Read and load formats
  localparam logic [1:0] FMT_LATCH = 2'h0;
  localparam logic [1:0] FMT_LSB   = 2'h1;
  localparam logic [1:0] FMT_MSB   = 2'h2;
  localparam logic [1:0] FMT_BOTH  = 2'h3;

  // Waveform modes; rate and square ignore the top select bit
  localparam logic [2:0] MODE_TERM      = 3'h0;
  localparam logic [2:0] MODE_ONESHOT   = 3'h1;
  localparam logic [1:0] MODE_RATE_LO   = 2'h2;
  localparam logic [1:0] MODE_SQUARE_LO = 2'h3;
  localparam logic [2:0] MODE_SW_STROBE = 3'h4;
  localparam logic [2:0] MODE_HW_STROBE = 3'h5;

  // Reset values
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [2:0]  MODE_RST = 3'h0;
  localparam logic [1:0]  FMT_RST  = 2'h3;
  localparam logic [7:0]  RD_RST   = 8'h00;
  localparam logic        OUT_RST  = 1'b1;

  // Count values that trigger waveform events
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_TWO = 16'h0002;

  // Count readback bundle
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } smdc_rd_s;

endpackage

// [verilog/smdc_counter.sv]
// Purpose: One programmable 16-bit down-counter channel, six waveforms.
// Assumes: Host strobes are one core clock wide; count clock and gate
//          are asynchronous pins.
// Notes:   Count clock is sampled, so it must be well below core_clk/4.
//
// Function
// - Loaded zero counts as the largest count
// - Mode 0: low on control, count when loaded
// - Mode 0: high at terminal until reprogrammed
// - Mode 0: low gate pauses, high resumes
// - Mode 0 single byte: rewrite reloads next clock
// - Mode 0 two bytes: low byte halts count
// - One-shot: high on control, gate edge triggers
// - One-shot: low for count, high at terminal
// - One-shot: gate low never stops pulse
// - One-shot: new count waits, retrigger restarts
// - Modes 2-5 high on control; start rules
// - Rate: one-clock low pulse every n
// - Rate: new count after current pulse
// - Rate/square: low gate forces high, stops
// - Square: odd n high longer by one
// - Square: new count after next transition
// - Software strobe: one low pulse at terminal
// - Software strobe: gate restart from loaded count
// - Hardware strobe: gate triggered single strobe
// - Counts down; square mode by two
// - Latch command freezes readback value
// - Control word field layout
// - Read/load field encoding
// - Mode field encoding

`timescale 1ns/1ps

module smdc_counter
  import smdc_pkg::*;
#(
  parameter logic [1:0] CHANNEL_ID = 2'h0
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_b_in,
  // Host strobes and data
  input  wire logic       wr_ctrl_in,
  input  wire logic       wr_count_in,
  input  wire logic       rd_count_in,
  input  wire logic [7:0] wr_data_in,
  // Channel pins
  input  wire logic       cnt_clk_in,
  input  wire logic       gate_in,
  // Results
  output logic            wave_out,
  output logic            counting_out,
  output logic [7:0]      rd_data_out,
  output logic            rd_valid_out
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  smdc_ctrl_s  cw;
  smdc_rd_s    rd_ff;
  logic [2:0]  mode_ff;
  logic [1:0]  fmt_ff;
  logic        bcd_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [15:0] reload_ff;
  logic [15:0] latch_val_ff;
  logic [15:0] dec_v;
  logic [15:0] dec2_v;
  logic [15:0] rd_src;
  logic        out_ff;
  logic        nxt_out;
  logic        run_ff;
  logic        nxt_run;
  logic        new_ff;
  logic        take_new;
  logic        partial_ff;
  logic        have_cr_ff;
  logic        restart_ff;
  logic        nxt_restart;
  logic        latched_ff;
  logic        rd_ptr_ff;
  logic        rd_last;
  logic        load_done;
  logic        clk_s1_ff;
  logic        clk_s2_ff;
  logic        clk_s3_ff;
  logic        gate_s1_ff;
  logic        gate_s2_ff;
  logic        gate_q_ff;
  logic        tick;
  logic        gate_s;
  logic        gate_rise;
  logic        ctrl_hit;
  logic        latch_hit;
  logic        m0;
  logic        m1;
  logic        m2;
  logic        m3;
  logic        m4;
  logic        m5;

  // ******************************************************************
  // Decrement helper
  // ******************************************************************
  // One step down, binary or four BCD decades; zero wraps to maximum
  function automatic logic [15:0] dec1(input logic [15:0] v,
                                       input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r      = v - 16'h0001;
    borrow = 1'b1;
    if (bcd) begin
      r = v;
      for (int i = 0; i < 4; i++) begin
        if (borrow) begin
          if (v[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = 4'h9;
          end else begin
            r[4*i +: 4] = v[4*i +: 4] - 4'h1;
            borrow      = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  // Two flops per pin; the third clock flop only feeds the edge finder
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_s1_ff  <= 1'b0;
      clk_s2_ff  <= 1'b0;
      clk_s3_ff  <= 1'b0;
      gate_s1_ff <= 1'b0;
      gate_s2_ff <= 1'b0;
    end else begin
      clk_s1_ff  <= cnt_clk_in;
      clk_s2_ff  <= clk_s1_ff;
      clk_s3_ff  <= clk_s2_ff;
      gate_s1_ff <= gate_in;
      gate_s2_ff <= gate_s1_ff;
    end
  end

  // Gate level as seen at the last count clock edge
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gate_q_ff <= 1'b0;
    end else if (tick) begin
      gate_q_ff <= gate_s;
    end
  end

  // Count tick and gate trigger, both on the count clock
  assign tick      = clk_s2_ff & ~clk_s3_ff;
  assign gate_s    = gate_s2_ff;
  assign gate_rise = tick & gate_s & ~gate_q_ff;

  // ******************************************************************
  // Control word decode
  // ******************************************************************
  // Illegal select 2'h3 never matches a channel id of 0..2
  assign cw        = smdc_ctrl_s'(wr_data_in);
  assign ctrl_hit  = wr_ctrl_in &
                     ({cw.channel_select_hi, cw.channel_select_lo}
                      == CHANNEL_ID) &
                     ({cw.load_format_hi, cw.load_format_lo}
                      != FMT_LATCH);
  assign latch_hit = wr_ctrl_in &
                     ({cw.channel_select_hi, cw.channel_select_lo}
                      == CHANNEL_ID) &
                     ({cw.load_format_hi, cw.load_format_lo}
                      == FMT_LATCH);

  // Mode decode; rate and square ignore the top bit
  assign m0 = (mode_ff == MODE_TERM);
  assign m1 = (mode_ff == MODE_ONESHOT);
  assign m2 = (mode_ff[1:0] == MODE_RATE_LO);
  assign m3 = (mode_ff[1:0] == MODE_SQUARE_LO);
  assign m4 = (mode_ff == MODE_SW_STROBE);
  assign m5 = (mode_ff == MODE_HW_STROBE);

  // Mode registers
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_ff <= MODE_RST;
      fmt_ff  <= FMT_RST;
      bcd_ff  <= 1'b0;
    end else if (ctrl_hit) begin
      mode_ff <= {cw.waveform_sel_2, cw.waveform_sel_1,
                  cw.waveform_sel_0};
      fmt_ff  <= {cw.load_format_hi, cw.load_format_lo};
      bcd_ff  <= cw.bcd_count;
    end
  end

  // ******************************************************************
  // Count value loading
  // ******************************************************************
  // Low byte of a two-byte load marks partial until the high byte
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reload_ff  <= CNT_RST;
      partial_ff <= 1'b0;
      have_cr_ff <= 1'b0;
    end else if (ctrl_hit) begin
      partial_ff <= 1'b0;
      have_cr_ff <= 1'b0;
    end else if (wr_count_in) begin
      case (fmt_ff)
        FMT_LSB: begin
          reload_ff <= {8'h00, wr_data_in};
        end
        FMT_MSB: begin
          reload_ff <= {wr_data_in, 8'h00};
        end
        FMT_BOTH: begin
          if (!partial_ff) begin
            reload_ff[7:0] <= wr_data_in;
          end else begin
            reload_ff[15:8] <= wr_data_in;
          end
          partial_ff <= ~partial_ff;
        end
        default: begin
          reload_ff <= reload_ff;
        end
      endcase
      if (load_done) begin
        have_cr_ff <= 1'b1;
      end
    end
  end

  // A complete count is waiting; a new arrival beats its consumption
  assign load_done = wr_count_in & (fmt_ff != FMT_LATCH) &
                     ((fmt_ff != FMT_BOTH) | partial_ff);

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      new_ff <= 1'b0;
    end else if (ctrl_hit) begin
      new_ff <= 1'b0;
    end else if (load_done) begin
      new_ff <= 1'b1;
    end else if (take_new) begin
      new_ff <= 1'b0;
    end
  end

  // ******************************************************************
  // Waveform engine
  // ******************************************************************
  assign dec_v  = dec1(count_ff, bcd_ff);
  assign dec2_v = dec1(dec_v, bcd_ff);

  // Next count, output and run state at each count tick
  always_comb begin
    nxt_count   = count_ff;
    nxt_out     = out_ff;
    nxt_run     = run_ff;
    nxt_restart = restart_ff;
    take_new    = 1'b0;
    if (tick) begin
      if ((m4 | m5) & ~out_ff) begin
        nxt_out = 1'b1;
      end
      if (m0 | m4) begin
        if (new_ff & ~partial_ff) begin
          nxt_count   = reload_ff;
          nxt_run     = 1'b1;
          nxt_restart = 1'b0;
          take_new    = 1'b1;
        end else if (run_ff & ~partial_ff) begin
          if (!gate_s) begin
            nxt_restart = m4;
          end else if (restart_ff) begin
            nxt_count   = reload_ff;
            nxt_restart = 1'b0;
          end else begin
            nxt_count = dec_v;
            if (count_ff == CNT_ONE) begin
              if (m0) begin
                nxt_out = 1'b1;
              end else begin
                nxt_out = 1'b0;
                nxt_run = 1'b0;
              end
            end
          end
        end
      end else if (m1 | m5) begin
        if (gate_rise & have_cr_ff) begin
          nxt_count = reload_ff;
          nxt_run   = 1'b1;
          take_new  = new_ff;
          nxt_out   = ~m1;
        end else if (run_ff) begin
          nxt_count = dec_v;
          if (count_ff == CNT_ONE) begin
            nxt_run = 1'b0;
            nxt_out = m1;
          end
        end
      end else if (m2 | m3) begin
        if (!gate_s) begin
          nxt_out = 1'b1;
          nxt_run = 1'b0;
        end else if (have_cr_ff & ((new_ff & ~run_ff) | gate_rise)) begin
          nxt_count = reload_ff;
          nxt_run   = 1'b1;
          nxt_out   = 1'b1;
          take_new  = new_ff;
        end else if (run_ff & m2) begin
          nxt_count = dec_v;
          if (count_ff == CNT_TWO) begin
            nxt_out = 1'b0;
          end else if (count_ff == CNT_ONE) begin
            nxt_count = reload_ff;
            nxt_out   = 1'b1;
            take_new  = new_ff;
          end
        end else if (run_ff) begin
          nxt_count = dec2_v;
          if ((count_ff == CNT_TWO) | (count_ff == CNT_ONE)) begin
            nxt_out  = ~out_ff;
            take_new = new_ff;
            // Odd count: the low half is one clock shorter
            nxt_count = (out_ff & reload_ff[0]) ?
                        dec1(reload_ff, bcd_ff) : reload_ff;
          end
        end
      end
    end
  end

  // Counter state; a control word re-initialises the channel
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_ff   <= CNT_RST;
      out_ff     <= OUT_RST;
      run_ff     <= 1'b0;
      restart_ff <= 1'b0;
    end else if (ctrl_hit) begin
      count_ff   <= CNT_RST;
      out_ff     <= ({cw.waveform_sel_2, cw.waveform_sel_1,
                      cw.waveform_sel_0} != MODE_TERM);
      run_ff     <= 1'b0;
      restart_ff <= 1'b0;
    end else begin
      count_ff   <= nxt_count;
      out_ff     <= nxt_out;
      run_ff     <= nxt_run;
      restart_ff <= nxt_restart;
    end
  end

  // ******************************************************************
  // Readback
  // ******************************************************************
  // Direct reads of a running count may tear; host halts first
  assign rd_src  = latched_ff ? latch_val_ff : count_ff;
  assign rd_last = (fmt_ff != FMT_BOTH) | rd_ptr_ff;

  // Latch holds until fully read; a repeat latch meanwhile is ignored
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_val_ff <= CNT_RST;
      latched_ff   <= 1'b0;
      rd_ptr_ff    <= 1'b0;
    end else if (ctrl_hit) begin
      latched_ff <= 1'b0;
      rd_ptr_ff  <= 1'b0;
    end else begin
      if (latch_hit & (~latched_ff | (rd_count_in & rd_last))) begin
        latch_val_ff <= count_ff;
        latched_ff   <= 1'b1;
      end else if (rd_count_in & rd_last) begin
        latched_ff <= 1'b0;
      end
      if (rd_count_in & (fmt_ff == FMT_BOTH)) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
    end
  end

  // Read data register, one cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_ff <= '{data: RD_RST, valid: 1'b0};
    end else begin
      rd_ff.valid <= rd_count_in;
      if (rd_count_in) begin
        rd_ff.data <= ((fmt_ff == FMT_MSB) | rd_ptr_ff) ?
                      rd_src[15:8] : rd_src[7:0];
      end
    end
  end

  assign wave_out     = out_ff;
  assign counting_out = run_ff;
  assign rd_data_out  = rd_ff.data;
  assign rd_valid_out = rd_ff.valid;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_ctrl_low_m0: assert property (
    ctrl_hit & (cw[3:1] == MODE_TERM) |=> !wave_out)
    else $error("mode 0 control word did not drive low");
  chk_ctrl_high: assert property (
    ctrl_hit & (cw[3:1] != MODE_TERM) |=> wave_out)
    else $error("control word did not drive high");
  chk_m0_stays_high: assert property (
    m0 & out_ff & !ctrl_hit |=> out_ff)
    else $error("mode 0 output fell without reprogramming");
  chk_m0_gate_hold: assert property (
    m0 & tick & run_ff & !gate_s & !new_ff & !ctrl_hit |=>
    $stable(count_ff))
    else $error("mode 0 counted with gate low");
  chk_partial_halt: assert property (
    m0 & partial_ff & !ctrl_hit |=> $stable(count_ff))
    else $error("counted during partial load");
  chk_m0_reload: assert property (
    m0 & tick & new_ff & !partial_ff & !ctrl_hit & !wr_count_in |=>
    count_ff == $past(reload_ff))
    else $error("new count not loaded on next clock");
  chk_oneshot_wait: assert property (
    m1 & !run_ff & !gate_rise & !ctrl_hit |=> !run_ff)
    else $error("one-shot started without trigger");
  chk_oneshot_run: assert property (
    m1 & run_ff & tick & (count_ff > CNT_ONE) & !ctrl_hit |=> run_ff)
    else $error("one-shot stopped early");
  chk_rate_pulse: assert property (
    m2 & run_ff & tick & gate_s & !gate_rise & (count_ff == CNT_TWO) &
    !ctrl_hit |=> !wave_out)
    else $error("rate pulse did not start");
  // Low pulse lasts exactly one count clock period
  chk_rate_width: assert property (
    m2 & tick & !out_ff & !ctrl_hit |=> wave_out)
    else $error("rate pulse wider than one count clock");
  chk_gate_force: assert property (
    (m2 | m3) & tick & !gate_s & !ctrl_hit |=> wave_out & !run_ff)
    else $error("low gate did not force high");
  chk_square_step: assert property (
    m3 & run_ff & tick & gate_s & !gate_rise & !bcd_ff &
    (count_ff > CNT_TWO) & !ctrl_hit |=>
    count_ff == $past(count_ff) - 16'h0002)
    else $error("square mode step not two");
  chk_latch_freeze: assert property (
    latch_hit & !latched_ff & !ctrl_hit |=>
    latched_ff && latch_val_ff == $past(count_ff))
    else $error("latch did not capture count");
  chk_strobe_width: assert property (
    (m4 | m5) & tick & !out_ff & !ctrl_hit |=> out_ff)
    else $error("strobe wider than one clock");

  cov_rate_pulse: cover property (m2 & $fell(out_ff));
  cov_square_odd: cover property (m3 & reload_ff[0] & $rose(out_ff));
  cov_oneshot_retrig: cover property (m1 & run_ff & gate_rise);
  cov_latch_read: cover property (latched_ff & rd_count_in & rd_last);

endmodule

// [sim/smdc_pin_model.sv]
// Purpose: Count clock and gate source for one counter channel.
// Assumes: Called from the bench just after a falling core clock edge.
// Notes:   Each tick is 15 core cycles, far below the sampling limit.

`timescale 1ns/1ps

// ********************************************************************
// Pin model
// ********************************************************************
module smdc_pin_model (
  // Core clock used for pacing
  input  wire logic core_clk_in,
  // Count pins
  output logic      cnt_clk_out,
  output logic      gate_out
);

  // Idle levels; the count clock stands still between ticks
  initial begin
    cnt_clk_out = 1'h0;
    gate_out    = 1'h0;
  end

  // One count clock period; gate settles well before the rising edge
  task automatic tick(input logic g);
    gate_out = g;
    repeat (3) @(negedge core_clk_in);
    cnt_clk_out = 1'h1;
    repeat (6) @(negedge core_clk_in);
    cnt_clk_out = 1'h0;
    repeat (6) @(negedge core_clk_in);
  endtask

endmodule

// [sim/smdc_counter_tb.sv]
// Purpose: Self-checking bench for the six-mode down counter channel.
// Assumes: Channel 0; host strobes driven at the falling clock edge.
// Notes:   Waveforms are judged once per count tick, after it settles.

`timescale 1ns/1ps

// ********************************************************************
// Bench top
// ********************************************************************
module smdc_counter_tb;
  import smdc_pkg::*;

  localparam int CYC_LIMIT = 12000;

  logic       core_clk_in;
  logic       rst_b_in;
  logic       wr_ctrl_in;
  logic       wr_count_in;
  logic       rd_count_in;
  logic [7:0] wr_data_in;
  logic       cnt_clk_in;
  logic       gate_in;
  logic       wave_out;
  logic       counting_out;
  logic [7:0] rd_data_out;
  logic       rd_valid_out;
  int         n_fail;
  int         cmp_count;
  int         cyc_count = 0;

  smdc_counter #(.CHANNEL_ID(2'h0)) i_dut (
    .core_clk_in  (core_clk_in),
    .rst_b_in     (rst_b_in),
    .wr_ctrl_in   (wr_ctrl_in),
    .wr_count_in  (wr_count_in),
    .rd_count_in  (rd_count_in),
    .wr_data_in   (wr_data_in),
    .cnt_clk_in   (cnt_clk_in),
    .gate_in      (gate_in),
    .wave_out     (wave_out),
    .counting_out (counting_out),
    .rd_data_out  (rd_data_out),
    .rd_valid_out (rd_valid_out)
  );

  smdc_pin_model i_pins (
    .core_clk_in (core_clk_in),
    .cnt_clk_out (cnt_clk_in),
    .gate_out    (gate_in)
  );

  // Core clock, 20 ns period
  initial begin
    core_clk_in = 1'h0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  // Verdict and end of run
  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cw(input logic e);
    chk({15'h0000, wave_out}, {15'h0000, e});
  endtask

  // One strobe; a spare cycle lets the write land before sampling
  task automatic wr(input logic c, input logic [7:0] d);
    @(negedge core_clk_in);
    wr_ctrl_in  = c;
    wr_count_in = ~c;
    wr_data_in  = d;
    @(negedge core_clk_in);
    wr_ctrl_in  = 1'h0;
    wr_count_in = 1'h0;
    @(negedge core_clk_in);
  endtask

  // Control word, then the level it must leave on the output
  task automatic prog(input logic [7:0] c, input logic e);
    wr(1'h1, c);
    cw(e);
  endtask

  // Read strobe; answer waited for under a short bound
  task automatic rd(input logic [7:0] exp);
    int k = 0;
    @(negedge core_clk_in);
    rd_count_in = 1'h1;
    @(negedge core_clk_in);
    rd_count_in = 1'h0;
    while (rd_valid_out !== 1'h1 && k < 2) begin
      @(negedge core_clk_in);
      k++;
    end
    chk({15'h0000, rd_valid_out}, 16'h0001);
    chk({8'h00, rd_data_out}, {8'h00, exp});
  endtask

  // Ticks with a gate pattern; bit i belongs to tick i
  task automatic run(input int n, input logic [15:0] g,
                     input logic [15:0] e);
    for (int i = 0; i < n; i++) begin
      i_pins.tick(g[i]);
      cw(e[i]);
    end
  endtask

  // Square wave: each window of n ticks starting at ticks 6 to 15 holds (n+1)/2 high ticks
  task automatic sq(input logic [7:0] c, input int n);
    logic [23:0] w;
    int          s;
    prog(c, 1'h1);
    wr(1'h0, n[7:0]);
    for (int i = 0; i < 24; i++) begin
      i_pins.tick(1'h1);
      w[i] = wave_out;
    end
    for (int i = 6; i < 16; i++) begin
      s = 0;
      for (int j = 0; j < n; j++) begin
        s += w[i+j];
      end
      chk(16'(s), 16'((n + 1) / 2));
    end
  endtask

  // Hang guard
  always @(posedge core_clk_in) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == CYC_LIMIT) begin
      n_fail++;
      conclude();
    end
  end

  // Main sequence
  initial begin
    n_fail      = 0;
    cmp_count   = 0;
    rst_b_in    = 1'h0;
    wr_ctrl_in  = 1'h0;
    wr_count_in = 1'h0;
    rd_count_in = 1'h0;
    wr_data_in  = 8'h00;
    repeat (2) @(negedge core_clk_in);
    chk({15'h0000, counting_out}, 16'h0000);
    rst_b_in = 1'h1;
    // Terminal count, two bytes, count held off until high byte
    prog(8'h30, 1'h0);
    wr(1'h0, 8'h03);
    run(2, 16'h0003, 16'h0000);
    wr(1'h0, 8'h00);
    run(1, 16'h0001, 16'h0000);
    chk({15'h0000, counting_out}, 16'h0001);
    run(5, 16'h001F, 16'h001C);
    // Gate low pauses and resumes
    prog(8'h10, 1'h0);
    wr(1'h0, 8'h04);
    run(7, 16'h0073, 16'h0040);
    // Single byte rewrite reloads
    prog(8'h10, 1'h0);
    wr(1'h0, 8'h06);
    run(2, 16'h0003, 16'h0000);
    wr(1'h0, 8'h02);
    run(3, 16'h0007, 16'h0004);
    // Low byte halts until high byte
    prog(8'h30, 1'h0);
    wr(1'h0, 8'h03);
    wr(1'h0, 8'h00);
    run(2, 16'h0003, 16'h0000);
    wr(1'h0, 8'h05);
    run(2, 16'h0003, 16'h0000);
    wr(1'h0, 8'h00);
    run(6, 16'h003F, 16'h0020);
    // Zero is the largest count; latch holds its value
    prog(8'h30, 1'h0);
    wr(1'h0, 8'h00);
    wr(1'h0, 8'h00);
    run(2, 16'h0003, 16'h0000);
    wr(1'h1, 8'h00);
    run(1, 16'h0001, 16'h0000);
    rd(8'hFF);
    rd(8'hFF);
    // High byte only format
    prog(8'h20, 1'h0);
    wr(1'h0, 8'h01);
    run(1, 16'h0001, 16'h0000);
    wr(1'h1, 8'h00);
    rd(8'h01);
    // One-shot; other channel's control word is ignored
    prog(8'h12, 1'h1);
    wr(1'h0, 8'h03);
    run(5, 16'h0002, 16'h0011);
    wr(1'h1, 8'h50);
    cw(1'h1);
    run(1, 16'h0001, 16'h0000);
    wr(1'h0, 8'h04);
    run(8, 16'h00F8, 16'h0084);
    run(8, 16'h00FA, 16'h0081);
    // Rate generator, late count change, gate stop
    prog(8'h14, 1'h1);
    wr(1'h0, 8'h03);
    run(4, 16'h000F, 16'h000B);
    wr(1'h0, 8'h04);
    run(6, 16'h003F, 16'h001D);
    run(9, 16'h01E7, 16'h00FF);
    prog(8'h1C, 1'h1);
    wr(1'h0, 8'h03);
    run(3, 16'h0007, 16'h0003);
    // Square wave, odd and even
    sq(8'h16, 5);
    sq(8'h1E, 4);
    // Software strobe, then gate restart from loaded count
    prog(8'h18, 1'h1);
    wr(1'h0, 8'h03);
    run(6, 16'h003F, 16'h0037);
    wr(1'h0, 8'h04);
    run(9, 16'h01FB, 16'h017F);
    // Hardware strobe
    prog(8'h1A, 1'h1);
    wr(1'h0, 8'h02);
    run(5, 16'h001E, 16'h0017);
    conclude();
  end

endmodule
